// [sim/fep_guard_chk.sv]
// port-level assertions for the flash error and protection block
`timescale 1ns/1ps
module fep_guard_chk
   import fep_pkg::*;
(
   input wire logic                   MCLK,
   input wire logic                   RESET_N,
   input wire logic                   FETCH_FROM_FLASH,
   input wire logic                   EV_SETUP_BAD,
   input wire logic                   EV_RESUME_BAD,
   input wire logic                   OP_REQ,
   input wire logic [FEP_SECTORS-1:0] OP_SECTORS,
   input wire logic [FEP_SECTORS-1:0] OP_GRANT,
   input wire logic                   OP_ABORT,
   input wire logic                   SETPROT_REQ,
   input wire logic                   SETPROT_DONE,
   input wire logic                   SETPROT_REFUSED,
   input wire logic                   NV_WR_REQ,
   input wire logic                   FUSES_LOADED,
   input wire logic [FEP_SECTORS-1:0] SECTOR_BLOCKED,
   input wire logic                   ACCESS_PROTECTED,
   input wire logic                   DATA_ACC_REQ,
   input wire logic                   DATA_ACC_BLOCK
);
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   a_grant_mask: assert property (
      OP_REQ |=> OP_GRANT == ($past(OP_SECTORS) & ~SECTOR_BLOCKED))
      else $error("grant differs from request minus blocked sectors");
   a_grant_idle: assert property (
      !OP_REQ |=> OP_GRANT == '0) else $error("grant without request");
   a_abort_cause: assert property (
      OP_ABORT == ($past(EV_SETUP_BAD) || $past(EV_RESUME_BAD)))
      else $error("abort does not follow setup or resume fault");
   a_refuse_flash: assert property (
      SETPROT_REQ && FETCH_FROM_FLASH |=> SETPROT_REFUSED && !SETPROT_DONE)
      else $error("fuse setting accepted while fetching from flash");
   a_refuse_unloaded: assert property (
      SETPROT_REQ && !FUSES_LOADED |=> SETPROT_REFUSED)
      else $error("fuse setting accepted before copies loaded");
   a_burn_done: assert property (
      SETPROT_DONE |-> NV_WR_REQ && $past(SETPROT_REQ))
      else $error("done without cell burn or request");
   a_guard_until_load: assert property (
      !FUSES_LOADED |-> SECTOR_BLOCKED == '1 && ACCESS_PROTECTED)
      else $error("protection relaxed before fuses loaded");
   a_data_block: assert property (
      DATA_ACC_BLOCK == ($past(DATA_ACC_REQ) && ACCESS_PROTECTED
                         && !$past(FETCH_FROM_FLASH)))
      else $error("data access block wrong");
   a_loaded_stays: assert property (
      FUSES_LOADED |=> FUSES_LOADED) else $error("loaded flag dropped");
   // ---------------------------------------------------------------
   // covers
   // ---------------------------------------------------------------
   c_grant: cover property (OP_REQ ##1 OP_GRANT != '0);
   c_refuse: cover property (SETPROT_REQ ##1 SETPROT_REFUSED);
   c_unguard: cover property ($fell(ACCESS_PROTECTED));
endmodule

bind fep_flash_guard fep_guard_chk fep_guard_chk_i (
   .MCLK(MCLK), .RESET_N(RESET_N), .FETCH_FROM_FLASH(FETCH_FROM_FLASH),
   .EV_SETUP_BAD(EV_SETUP_BAD), .EV_RESUME_BAD(EV_RESUME_BAD),
   .OP_REQ(OP_REQ), .OP_SECTORS(OP_SECTORS), .OP_GRANT(OP_GRANT),
   .OP_ABORT(OP_ABORT), .SETPROT_REQ(SETPROT_REQ),
   .SETPROT_DONE(SETPROT_DONE), .SETPROT_REFUSED(SETPROT_REFUSED),
   .NV_WR_REQ(NV_WR_REQ), .FUSES_LOADED(FUSES_LOADED),
   .SECTOR_BLOCKED(SECTOR_BLOCKED), .ACCESS_PROTECTED(ACCESS_PROTECTED),
   .DATA_ACC_REQ(DATA_ACC_REQ), .DATA_ACC_BLOCK(DATA_ACC_BLOCK));

// [sim/tb.sv]
// self-checking bench for the flash error and protection block
`timescale 1ns/1ps
module tb;
   import fep_pkg::*;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, fetch = 0, busy = 0;
   logic fuse_prog = 0, op_req = 0, sp_req = 0, ack = 0, acc_req = 0;
   logic [23:0] addr = 0;
   logic [15:0] wdata = 0, nv_data = 0, sp_data = 0, rdata, nvw_data;
   logic [5:0]  ev = 0;
   logic [9:0]  op_sec = 0, grant, blocked;
   logic [1:0]  sp_idx = 0, nv_idx, nvw_idx;
   logic [2:0]  n_ld = 0;
   logic rvalid, abort, sp_done, sp_ref, nvw, nvr, loaded, prot, acc_blk, dbg;
   logic [15:0] nv [4] = '{16'hfdfe, 16'hacfc, 16'hffff, 16'hffff};
   logic [15:0] fl [6] = '{16'h1, 16'h2, 16'h4, 16'h8, 16'h41, 16'h80};
   int err_count = 0, compares = 0;

   always #2 clk = ~clk;

   fep_flash_guard fep_flash_guard_i (
      .MCLK(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WR(wr),
      .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
      .FETCH_FROM_FLASH(fetch), .BANK0_BUSY(busy), .EV_WRITE_FAIL(ev[0]),
      .EV_ERASE_FAIL(ev[1]), .EV_PROGRAM_FAIL(ev[2]),
      .EV_ONE_OVER_ZERO(ev[3]), .EV_FUSE_PROGRAM(fuse_prog),
      .EV_SETUP_BAD(ev[4]), .EV_RESUME_BAD(ev[5]), .OP_REQ(op_req),
      .OP_SECTORS(op_sec), .OP_GRANT(grant), .OP_ABORT(abort),
      .SETPROT_REQ(sp_req), .SETPROT_IDX(sp_idx), .SETPROT_DATA(sp_data),
      .SETPROT_DONE(sp_done), .SETPROT_REFUSED(sp_ref), .NV_WR_REQ(nvw),
      .NV_WR_IDX(nvw_idx), .NV_WR_DATA(nvw_data), .NV_RD_REQ(nvr),
      .NV_RD_IDX(nv_idx), .NV_RD_DATA(nv_data), .NV_RD_ACK(ack),
      .FUSES_LOADED(loaded), .SECTOR_BLOCKED(blocked),
      .ACCESS_PROTECTED(prot), .DATA_ACC_REQ(acc_req),
      .DATA_ACC_BLOCK(acc_blk), .DEBUG_ENABLE(dbg));

   // ---------------------------------------------------------------
   // fuse cells: answer each read once, in index order
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      #1;
      ack <= 1'b0;
      if (!rst_n) begin
         n_ld <= 3'h0;
      end else if (nvr && nv_idx == n_ld[1:0] && !ack && n_ld < 3'h4) begin
         ack <= 1'b1;
         nv_data <= nv[nv_idx];
         n_ld <= n_ld + 3'h1;
      end
   end

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wreg(input logic [23:0] a, input logic [15:0] d);
      @(posedge clk) #1 addr = a;
      wdata = d;
      wr = 1;
      @(posedge clk) #1 wr = 0;
   endtask
   task automatic rreg(input logic [23:0] a, input logic [15:0] e);
      @(posedge clk) #1 addr = a;
      rd = 1;
      @(posedge clk) #1 rd = 0;
      chk({15'h0, rvalid}, 16'h1);
      chk(rdata, e);
   endtask
   task automatic pulse(input logic [5:0] v);
      @(posedge clk) #1 ev = v;
      @(posedge clk) #1 ev = 0;
   endtask
   task automatic op(input logic [9:0] s, input logic [9:0] g);
      @(posedge clk) #1 op_sec = s;
      op_req = 1;
      @(posedge clk) #1 op_req = 0;
      chk({6'h0, grant}, {6'h0, g});
   endtask
   task automatic setp(input logic [1:0] i, input logic [15:0] d,
                       input logic ok);
      @(posedge clk) #1 sp_idx = i;
      sp_data = d;
      sp_req = 1;
      @(posedge clk) #1 sp_req = 0;
      chk({11'h0, nvw_idx, sp_done, sp_ref, nvw}, {11'h0, i, ok, !ok, ok});
   endtask
   task automatic close_out;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      #20000;
      err_count++;
      close_out;
   end

   initial begin
      tick(3);
      chk({5'h0, prot, blocked}, 16'h07ff);
      rst_n = 1;
      setp(2'h2, 16'hfffe, 1'b0);
      for (int k = 0; k < 60 && !loaded; k++) tick(1);
      chk({3'h0, loaded, dbg, prot, blocked}, 16'h1601);
      rreg(FEP_ADDR_WGUARD, 16'h01fe);
      rreg(FEP_ADDR_AGUARD, 16'h0000);
      rreg(24'h08dfa0, 16'h0000);
      $display("test load done");
      for (int i = 0; i < 6; i++) begin
         pulse(6'h1 << i);
         chk({15'h0, abort}, {15'h0, i > 3});
         rreg(FEP_ADDR_FAULT, fl[i]);
         wreg(FEP_ADDR_FAULT, 16'h0000);
         rreg(FEP_ADDR_FAULT, 16'h0000);
      end
      pulse(6'h02);
      wreg(FEP_ADDR_FAULT, 16'hffff);
      rreg(FEP_ADDR_FAULT, 16'h0002);
      wreg(FEP_ADDR_FAULT, 16'hfffd);
      busy = 1;
      pulse(6'h04);
      rreg(FEP_ADDR_FAULT, 16'h0000);
      busy = 0;
      tick(3);
      rreg(FEP_ADDR_FAULT, 16'h0004);
      wreg(FEP_ADDR_FAULT, 16'h0000);
      fuse_prog = 1;
      pulse(6'h08);
      fuse_prog = 0;
      rreg(FEP_ADDR_FAULT, 16'h0000);
      $display("test fault flags done");
      op(10'h3ff, 10'h1fe);
      rreg(FEP_ADDR_FAULT, 16'h0100);
      wreg(FEP_ADDR_FAULT, 16'h0000);
      op(10'h006, 10'h006);
      rreg(FEP_ADDR_FAULT, 16'h0000);
      setp(2'h0, 16'hffff, 1'b1);
      chk(nvw_data, 16'h01fe);
      tick(2);
      chk({6'h0, blocked}, 16'h0000);
      $display("test sector guard done");
      acc_req = 1;
      tick(2);
      chk({15'h0, acc_blk}, 16'h1);
      fetch = 1;
      tick(2);
      chk({15'h0, acc_blk}, 16'h0);
      wreg(FEP_ADDR_TEMPUG, 16'h0001);
      tick(2);
      chk({15'h0, prot}, 16'h0);
      setp(2'h2, 16'hfffe, 1'b0);
      fetch = 0;
      wreg(FEP_ADDR_TEMPUG, 16'h0000);
      wreg(FEP_ADDR_TEMPUG, 16'h0001);
      tick(2);
      chk({14'h0, prot, acc_blk}, 16'h3);
      $display("test access guard done");
      setp(2'h2, 16'hfffe, 1'b1);
      chk(nvw_data, 16'hfffe);
      tick(2);
      chk({15'h0, prot}, 16'h0);
      setp(2'h2, 16'hfffc, 1'b1);
      rreg(FEP_ADDR_DISABLE, 16'hfffe);
      setp(2'h3, 16'hfffc, 1'b1);
      rreg(FEP_ADDR_REENAB, 16'hfffe);
      chk({15'h0, prot}, 16'h1);
      setp(2'h2, 16'hfffc, 1'b1);
      rreg(FEP_ADDR_DISABLE, 16'hfffc);
      chk({15'h0, prot}, 16'h0);
      setp(2'h3, 16'hffff, 1'b1);
      rreg(FEP_ADDR_REENAB, 16'hfffe);
      $display("test fuse pairs done");
      close_out;
   end
endmodule

// [verilog/fep_flash_guard.sv]
// flash fault flags and protection logic of the embedded flash controller
//
// Contract
// - fault flags only change when bank busy is low; valid when lock low; a zero write still clears flags while busy is high
// - write failure or bad write setup sets bit 0, held until cleared
// - cell erase failure sets bit 1, held until cleared
// - cell program failure sets bit 2, held until cleared
// - programming zero back to one sets bit 3, not for fuse programming
// - invalid setup performs no write and sets bit 6
// - bad resume aborts suspended operation and sets bit 7
// - guarded sector hit sets bit 8; unguarded sectors still erased
// - fuses read once at reset into four volatile copies used for checks
// - until fuses are read every protection is active
// - fuse programming refused while code is fetched from flash
// - fuses program once only: bits can only go from one to zero; programming a sector guard one lifts the copy
// - sector guard bit zero blocks write and erase of that sector
// - access guard zero blocks data access unless fetching from flash
// - debug guard one permits test bypass; zero disables all debug
// - disable x zero with re-enable x one ignores the access guard
// - re-enable x zero with disable x+1 one applies the guard again
// - disable 0 programmable only after debug and access guards are zero
// - disable x programmable only after re-enable x-1 is zero
// - re-enable x programmable only after disable x is zero
// - access protection needs access guard zero and temp unguard zero
`timescale 1ns/1ps
module fep_flash_guard
   import fep_pkg::*;
(
   input  wire logic                   MCLK,
   input  wire logic                   RESET_N,
   input  wire logic [23:0]            REG_ADDR,
   input  wire logic                   REG_WR,
   input  wire logic                   REG_RD,
   input  wire logic [15:0]            REG_WDATA,
   output logic [15:0]                 REG_RDATA,
   output logic                        REG_RVALID,
   input  wire logic                   FETCH_FROM_FLASH,
   input  wire logic                   BANK0_BUSY,
   input  wire logic                   EV_WRITE_FAIL,
   input  wire logic                   EV_ERASE_FAIL,
   input  wire logic                   EV_PROGRAM_FAIL,
   input  wire logic                   EV_ONE_OVER_ZERO,
   input  wire logic                   EV_FUSE_PROGRAM,
   input  wire logic                   EV_SETUP_BAD,
   input  wire logic                   EV_RESUME_BAD,
   input  wire logic                   OP_REQ,
   input  wire logic [FEP_SECTORS-1:0] OP_SECTORS,
   output logic [FEP_SECTORS-1:0]      OP_GRANT,
   output logic                        OP_ABORT,
   input  wire logic                   SETPROT_REQ,
   input  wire logic [1:0]             SETPROT_IDX,
   input  wire logic [15:0]            SETPROT_DATA,
   output logic                        SETPROT_DONE,
   output logic                        SETPROT_REFUSED,
   output logic                        NV_WR_REQ,
   output logic [1:0]                  NV_WR_IDX,
   output logic [15:0]                 NV_WR_DATA,
   output logic                        NV_RD_REQ,
   output logic [1:0]                  NV_RD_IDX,
   input  wire logic [15:0]            NV_RD_DATA,
   input  wire logic                   NV_RD_ACK,
   output logic                        FUSES_LOADED,
   output logic [FEP_SECTORS-1:0]      SECTOR_BLOCKED,
   output logic                        ACCESS_PROTECTED,
   input  wire logic                   DATA_ACC_REQ,
   output logic                        DATA_ACC_BLOCK,
   output logic                        DEBUG_ENABLE
);
   import fep_pkg::*;

   // -----------------------------------------------------------------
   // fuse loader
   // -----------------------------------------------------------------
   logic        ld_valid;
   logic [1:0]  ld_idx;
   logic [15:0] ld_data;
   logic        ld_done;
   logic        ld_rd_req;
   logic [1:0]  ld_rd_idx;

   fep_fuse_loader u_loader (
      .clk        (MCLK),
      .reset_n    (RESET_N),
      .rd_req     (ld_rd_req),
      .rd_idx     (ld_rd_idx),
      .rd_data    (NV_RD_DATA),
      .rd_ack     (NV_RD_ACK),
      .word_valid (ld_valid),
      .word_idx   (ld_idx),
      .word_data  (ld_data),
      .done       (ld_done)
   );

   // -----------------------------------------------------------------
   // volatile protection copies
   // -----------------------------------------------------------------
   logic [FEP_SECTORS-1:0] wguard;
   logic [1:0]             aguard;
   logic [FEP_PAIRS-1:0]   dis;
   logic [FEP_PAIRS-1:0]   ren;
   logic                   loaded;
   logic                   temp_unguard;
   logic [FEP_SECTORS-1:0] next_wguard;
   logic [1:0]             next_aguard;
   logic [FEP_PAIRS-1:0]   next_dis;
   logic [FEP_PAIRS-1:0]   next_ren;
   logic                   next_loaded;
   logic                   next_temp_unguard;

   // which fuse bits may legally be driven to zero right now
   logic [FEP_PAIRS-1:0]   dis_allowed;
   logic [FEP_PAIRS-1:0]   ren_allowed;
   logic [FEP_PAIRS-1:0]   pair_off;
   logic                   guard_ignored;

   genvar gi;
   generate
      for (gi = 0; gi < FEP_PAIRS; gi = gi + 1) begin : g_pair
         if (gi == 0) begin : g_first
            assign dis_allowed[gi] = ~aguard[FEP_BIT_DEBUG]
                                   & ~aguard[FEP_BIT_ACCESS];
         end else begin : g_rest
            assign dis_allowed[gi] = ~ren[gi-1];
         end
         assign ren_allowed[gi] = ~dis[gi];
         // chain: each disable/re-enable pair toggles the guard once
         assign pair_off[gi] = ~dis[gi] & ren[gi];
      end
   endgenerate

   assign guard_ignored = |pair_off;

   // -----------------------------------------------------------------
   // fuse programming
   // -----------------------------------------------------------------
   logic        prot_ok;
   logic [15:0] prot_old;
   logic [15:0] prot_new;
   logic        next_setprot_done;
   logic        next_setprot_refused;
   logic        next_nv_wr_req;
   logic [1:0]  next_nv_wr_idx;
   logic [15:0] next_nv_wr_data;

   always_comb begin
      prot_old = FEP_PAIR_RESET;
      prot_new = FEP_PAIR_RESET;
      unique case (SETPROT_IDX)
         FEP_IDX_WGUARD: begin
            prot_old = {6'h00, wguard};
            prot_new = SETPROT_DATA & FEP_WGUARD_MASK;
         end
         FEP_IDX_AGUARD: begin
            prot_old = {14'h0000, aguard};
            // one-time cells: only ones may be cleared
            prot_new = prot_old & SETPROT_DATA
                     & FEP_AGUARD_MASK;
         end
         FEP_IDX_DISABLE: begin
            prot_old = dis;
            prot_new = dis & (SETPROT_DATA | ~dis_allowed);
         end
         FEP_IDX_REENAB: begin
            prot_old = ren;
            prot_new = ren & (SETPROT_DATA | ~ren_allowed);
         end
      endcase
      prot_ok = SETPROT_REQ & loaded & ~FETCH_FROM_FLASH;
      next_setprot_done    = prot_ok;
      next_setprot_refused = SETPROT_REQ & ~prot_ok;
      next_nv_wr_req       = prot_ok;
      next_nv_wr_idx       = SETPROT_IDX;
      // sector cells keep earlier zeros; a one only lifts the copy
      next_nv_wr_data      = (SETPROT_IDX == FEP_IDX_WGUARD)
                           ? (prot_new & prot_old) : prot_new;
   end

   always_comb begin
      next_wguard       = wguard;
      next_aguard       = aguard;
      next_dis          = dis;
      next_ren          = ren;
      next_loaded       = loaded | ld_done;
      next_temp_unguard = temp_unguard;
      if (ld_valid) begin
         unique case (ld_idx)
            FEP_IDX_WGUARD:  next_wguard = ld_data[FEP_SECTORS-1:0];
            FEP_IDX_AGUARD:  next_aguard = ld_data[1:0];
            FEP_IDX_DISABLE: next_dis = ld_data;
            FEP_IDX_REENAB:  next_ren = ld_data;
         endcase
      end
      if (prot_ok) begin
         unique case (SETPROT_IDX)
            FEP_IDX_WGUARD:  next_wguard = prot_new[FEP_SECTORS-1:0];
            FEP_IDX_AGUARD:  next_aguard = prot_new[1:0];
            FEP_IDX_DISABLE: next_dis = prot_new;
            FEP_IDX_REENAB:  next_ren = prot_new;
         endcase
      end
      // setting the bit is only possible from flash code
      if (REG_WR && REG_ADDR == FEP_ADDR_TEMPUG) begin
         if (!REG_WDATA[0] || FETCH_FROM_FLASH) begin
            next_temp_unguard = REG_WDATA[0];
         end
      end
   end

   // -----------------------------------------------------------------
   // effective protection
   // -----------------------------------------------------------------
   logic                   acc_prot;
   logic [FEP_SECTORS-1:0] blocked;
   logic [FEP_SECTORS-1:0] next_op_grant;
   logic                   next_op_abort;
   logic                   next_data_block;
   logic                   next_debug;

   always_comb begin
      // before the copies exist everything counts as protected
      blocked  = loaded ? ~wguard : {FEP_SECTORS{1'b1}};
      acc_prot = ~loaded
               | (~aguard[FEP_BIT_ACCESS] & ~temp_unguard
                  & ~guard_ignored);
      next_data_block = DATA_ACC_REQ & acc_prot & ~FETCH_FROM_FLASH;
      next_debug      = loaded & aguard[FEP_BIT_DEBUG];
      next_op_grant   = OP_REQ ? (OP_SECTORS & ~blocked)
                               : {FEP_SECTORS{1'b0}};
      next_op_abort   = EV_SETUP_BAD | EV_RESUME_BAD;
   end

   // -----------------------------------------------------------------
   // fault flags
   // -----------------------------------------------------------------
   logic [15:0] fault;
   logic [15:0] pending;
   logic [15:0] events;
   logic [15:0] clr;
   logic [15:0] next_fault;
   logic [15:0] next_pending;

   always_comb begin
      events = 16'h0000;
      events[FEP_BIT_WRITE_ERR] = EV_WRITE_FAIL | EV_SETUP_BAD;
      events[FEP_BIT_ERASE]     = EV_ERASE_FAIL;
      events[FEP_BIT_PROGRAM]   = EV_PROGRAM_FAIL;
      events[FEP_BIT_ONE_OVER]  = EV_ONE_OVER_ZERO
                                & ~EV_FUSE_PROGRAM;
      events[FEP_BIT_SETUP]     = EV_SETUP_BAD;
      events[FEP_BIT_RESUME]    = EV_RESUME_BAD;
      events[FEP_BIT_GUARD_HIT] = OP_REQ
                                & (|(OP_SECTORS & blocked));
      // writing zero to a flag clears it
      clr = 16'h0000;
      if (REG_WR && REG_ADDR == FEP_ADDR_FAULT) begin
         clr = ~REG_WDATA & FEP_FAULT_MASK;
      end
      // events wait while busy, so software never sees a half result
      if (BANK0_BUSY) begin
         next_pending = pending | events;
         next_fault   = fault & ~clr;
      end else begin
         next_pending = 16'h0000;
         next_fault   = (fault & ~clr) | pending | events;
      end
   end

   // -----------------------------------------------------------------
   // register read port
   // -----------------------------------------------------------------
   logic [15:0] next_rdata;

   always_comb begin
      next_rdata = 16'h0000;
      unique case (REG_ADDR)
         FEP_ADDR_FAULT:   next_rdata = fault & FEP_FAULT_MASK;
         FEP_ADDR_WGUARD:  next_rdata = {6'h00, wguard};
         FEP_ADDR_AGUARD:  next_rdata = {14'h0000, aguard};
         FEP_ADDR_DISABLE: next_rdata = dis;
         FEP_ADDR_REENAB:  next_rdata = ren;
         FEP_ADDR_TEMPUG:  next_rdata = {15'h0000, temp_unguard};
         default:          next_rdata = 16'h0000;
      endcase
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         wguard           <= FEP_WGUARD_RESET[FEP_SECTORS-1:0];
         aguard           <= FEP_AGUARD_RESET[1:0];
         dis              <= FEP_PAIR_RESET;
         ren              <= FEP_PAIR_RESET;
         loaded           <= 1'b0;
         temp_unguard     <= 1'b0;
         fault            <= FEP_FAULT_RESET;
         pending          <= FEP_FAULT_RESET;
         REG_RDATA        <= 16'h0000;
         REG_RVALID       <= 1'b0;
         OP_GRANT         <= {FEP_SECTORS{1'b0}};
         OP_ABORT         <= 1'b0;
         SETPROT_DONE     <= 1'b0;
         SETPROT_REFUSED  <= 1'b0;
         NV_WR_REQ        <= 1'b0;
         NV_WR_IDX        <= 2'h0;
         NV_WR_DATA       <= 16'h0000;
         FUSES_LOADED     <= 1'b0;
         SECTOR_BLOCKED   <= {FEP_SECTORS{1'b1}};
         ACCESS_PROTECTED <= 1'b1;
         DATA_ACC_BLOCK   <= 1'b0;
         DEBUG_ENABLE     <= 1'b0;
      end else begin
         wguard           <= next_wguard;
         aguard           <= next_aguard;
         dis              <= next_dis;
         ren              <= next_ren;
         loaded           <= next_loaded;
         temp_unguard     <= next_temp_unguard;
         fault            <= next_fault;
         pending          <= next_pending;
         REG_RDATA        <= next_rdata;
         REG_RVALID       <= REG_RD;
         OP_GRANT         <= next_op_grant;
         OP_ABORT         <= next_op_abort;
         SETPROT_DONE     <= next_setprot_done;
         SETPROT_REFUSED  <= next_setprot_refused;
         NV_WR_REQ        <= next_nv_wr_req;
         NV_WR_IDX        <= next_nv_wr_idx;
         NV_WR_DATA       <= next_nv_wr_data;
         FUSES_LOADED     <= loaded;
         SECTOR_BLOCKED   <= blocked;
         ACCESS_PROTECTED <= acc_prot;
         DATA_ACC_BLOCK   <= next_data_block;
         DEBUG_ENABLE     <= next_debug;
      end
   end

   // loader read strobe is itself a flip-flop inside the loader
   assign NV_RD_REQ = ld_rd_req;
   assign NV_RD_IDX = ld_rd_idx;
endmodule

// [verilog/fep_fuse_loader.sv]
// reads the four non-volatile protection registers once after reset
`timescale 1ns/1ps
module fep_fuse_loader
   import fep_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   output logic             rd_req,
   output logic [1:0]       rd_idx,
   input  wire logic [15:0] rd_data,
   input  wire logic        rd_ack,
   output logic             word_valid,
   output logic [1:0]       word_idx,
   output logic [15:0]      word_data,
   output logic             done
);
   import fep_pkg::*;

   fep_load_e   state;
   fep_load_e   next_state;
   logic [1:0]  next_rd_idx;
   logic        next_rd_req;
   logic        next_word_valid;
   logic [15:0] next_word_data;

   always_comb begin
      next_state      = state;
      next_rd_idx     = rd_idx;
      next_rd_req     = 1'b0;
      next_word_valid = 1'b0;
      next_word_data  = word_data;
      unique case (state)
         FEP_LD_REQ: begin
            next_rd_req = 1'b1;
            next_state  = FEP_LD_WAIT;
         end
         FEP_LD_WAIT: begin
            next_rd_req = ~rd_ack;
            if (rd_ack) begin
               next_word_valid = 1'b1;
               next_word_data  = rd_data;
               if (rd_idx == FEP_IDX_LAST) begin
                  next_state = FEP_LD_DONE;
               end else begin
                  next_rd_idx = rd_idx + 2'h1;
                  next_state  = FEP_LD_REQ;
               end
            end
         end
         FEP_LD_DONE: begin
            next_state = FEP_LD_DONE;
         end
         default: begin
            next_state = FEP_LD_DONE;
         end
      endcase
   end

   // one read per register, never repeated until the next reset
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state      <= FEP_LD_REQ;
         rd_idx     <= FEP_IDX_WGUARD;
         rd_req     <= 1'b0;
         word_valid <= 1'b0;
         word_data  <= 16'h0000;
      end else begin
         state      <= next_state;
         rd_idx     <= next_rd_idx;
         rd_req     <= next_rd_req;
         word_valid <= next_word_valid;
         word_data  <= next_word_data;
      end
   end

   // read index steps on with the ack, except after the last word
   assign word_idx = done ? rd_idx : rd_idx - 2'h1;
   assign done     = (state == FEP_LD_DONE);
endmodule

// [verilog/fep_pkg.sv]
// constants, register map and types of the flash error and protection block
package fep_pkg;
   // -----------------------------------------------------------------
   // register addresses (16-bit registers, even byte addresses)
   // -----------------------------------------------------------------
   localparam logic [23:0] FEP_ADDR_FAULT   = 24'h080014;
   localparam logic [23:0] FEP_ADDR_WGUARD  = 24'h08dfb0;
   localparam logic [23:0] FEP_ADDR_AGUARD  = 24'h08dfb8;
   localparam logic [23:0] FEP_ADDR_DISABLE = 24'h08dfbc;
   localparam logic [23:0] FEP_ADDR_REENAB  = 24'h08dfbe;
   localparam logic [23:0] FEP_ADDR_TEMPUG  = 24'h08dfc0;

   // -----------------------------------------------------------------
   // fault flag positions
   // -----------------------------------------------------------------
   localparam int FEP_BIT_WRITE_ERR = 0;
   localparam int FEP_BIT_ERASE     = 1;
   localparam int FEP_BIT_PROGRAM   = 2;
   localparam int FEP_BIT_ONE_OVER  = 3;
   localparam int FEP_BIT_SETUP     = 6;
   localparam int FEP_BIT_RESUME    = 7;
   localparam int FEP_BIT_GUARD_HIT = 8;
   localparam logic [15:0] FEP_FAULT_MASK = 16'h01cf;
   localparam logic [15:0] FEP_FAULT_RESET = 16'h0000;

   // -----------------------------------------------------------------
   // protection fields
   // -----------------------------------------------------------------
   localparam int FEP_BIT_ACCESS = 0;
   localparam int FEP_BIT_DEBUG  = 1;
   localparam int FEP_SECTORS    = 10;
   localparam int FEP_PAIRS      = 16;
   localparam logic [15:0] FEP_AGUARD_RESET = 16'hacff;
   localparam logic [15:0] FEP_PAIR_RESET   = 16'hffff;
   localparam logic [15:0] FEP_WGUARD_RESET = 16'hffff;
   localparam logic [15:0] FEP_WGUARD_MASK  = 16'h03ff;
   localparam logic [15:0] FEP_AGUARD_MASK  = 16'h0003;

   // -----------------------------------------------------------------
   // fuse register index on the non-volatile cell port
   // -----------------------------------------------------------------
   localparam logic [1:0] FEP_IDX_WGUARD  = 2'h0;
   localparam logic [1:0] FEP_IDX_AGUARD  = 2'h1;
   localparam logic [1:0] FEP_IDX_DISABLE = 2'h2;
   localparam logic [1:0] FEP_IDX_REENAB  = 2'h3;
   localparam logic [1:0] FEP_IDX_LAST    = 2'h3;

   typedef enum logic [1:0] {
      FEP_LD_REQ  = 2'b00,
      FEP_LD_WAIT = 2'b01,
      FEP_LD_DONE = 2'b11
   } fep_load_e;
endpackage
